// File: hdl/sbh_proc_end.sv
`timescale 1ns/1ps
module sbh_proc_end
  import sbh_pkg::*;
#(
  parameter int DEPTH = sbh_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      sys_rst_in,
  // Link
  sbh_if.proc                            bus,
  // Request port
  input  wire logic                      req_valid_in,
  output logic                           req_ready_out,
  input  wire logic                      req_write_in,
  input  wire logic [sbh_pkg::AD_W-1:0]  req_addr_in,
  input  wire logic [sbh_pkg::AD_W-1:0]  req_wdata_in,
  // Read data and agent writes
  output logic                           rsp_valid_out,
  input  wire logic                      rsp_ready_in,
  output logic [sbh_pkg::AD_W-1:0]       rsp_data_out,
  // Modes
  output logic                           mode_done_out,
  output logic [sbh_pkg::MODE_BITS-1:0]  mode_bits_out,
  output logic [3:0]                     pipe_mult_out
);
  import sbh_pkg::*;

  typedef enum logic [2:0] {
    SBH_IDLE   = 3'b000,
    SBH_ADDR   = 3'b001,
    SBH_WDATA  = 3'b010,
    SBH_RWAIT  = 3'b011,
    SBH_SLAVE  = 3'b100
  } sbh_state_e;

  sbh_state_e state;
  sbh_state_e next_state;
  logic            is_write;
  logic [AD_W-1:0] wdata;
  logic [AD_W-1:0] ad_out;
  logic [CMD_W-1:0] cmd_out;
  logic            drive;
  logic            rd_pending;

  // Synchronised pins
  logic [1:0] req_s, rrdy_s, wrdy_s, pg_s, md_s;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_s  <= 2'h3;
      rrdy_s <= 2'h3;
      wrdy_s <= 2'h3;
      pg_s   <= 2'h0;
      md_s   <= 2'h0;
    end else begin
      req_s  <= {req_s[0], bus.ext_bus_request_n};
      rrdy_s <= {rrdy_s[0], bus.read_accept_n};
      wrdy_s <= {wrdy_s[0], bus.write_accept_n};
      pg_s   <= {pg_s[0], bus.power_good};
      md_s   <= {md_s[0], bus.mode_data};
    end
  end
  wire ext_req  = ~req_s[1];
  wire rd_ok    = ~rrdy_s[1];
  wire wr_ok    = ~wrdy_s[1];
  // Agent valid qualifies the word on the bus in the same cycle: delaying it
  // would capture whatever follows the word
  wire agent_v  = ~bus.agent_drive_valid_n;

  // Data arriving while slave is buffered toward the user
  wire            fifo_ready;
  wire [CMD_W-1:0] cmd_in = bus.command_id_bus;
  wire is_data_in = cmd_in[CMD_DATA_BIT];
  wire fifo_push  = (state == SBH_SLAVE) & agent_v & is_data_in;
  sbh_fifo #(.WIDTH(AD_W), .DEPTH(DEPTH)) u_rx (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (bus.shared_addr_data_bus),
    .out_valid_out (rsp_valid_out),
    .out_ready_in  (rsp_ready_in),
    .out_data_out  (rsp_data_out)
  );

  // Agent hands back by dropping its request, with no read pending and a free buffer slot
  wire handback = ~ext_req & ~rd_pending & fifo_ready;
  wire can_issue = req_write_in ? wr_ok : rd_ok;
  assign req_ready_out = (state == SBH_IDLE) & ~ext_req & can_issue
                         & ~rd_pending;

  always_comb begin
    next_state = state;
    case (state)
      SBH_IDLE: begin
        if (ext_req)
          next_state = SBH_SLAVE;
        else if (req_valid_in & req_ready_out)
          next_state = SBH_ADDR;
      end
      SBH_ADDR:  next_state = is_write ? SBH_WDATA : SBH_RWAIT;
      SBH_WDATA: next_state = SBH_IDLE;
      SBH_RWAIT: next_state = SBH_SLAVE;
      SBH_SLAVE: begin
        if (handback)
          next_state = SBH_IDLE;
      end
      default:   next_state = SBH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state      <= SBH_IDLE;
      is_write   <= 1'b0;
      wdata      <= '0;
      ad_out     <= '0;
      cmd_out    <= CMD_NULL;
      drive      <= 1'b0;
      rd_pending <= 1'b0;
    end else begin
      state <= next_state;
      if (state == SBH_IDLE && next_state == SBH_ADDR) begin
        is_write <= req_write_in;
        wdata    <= req_wdata_in;
        ad_out   <= req_addr_in;
        cmd_out  <= req_write_in ? CMD_WRITE : CMD_READ;
        drive    <= 1'b1;
        rd_pending <= ~req_write_in;
      end else if (state == SBH_ADDR && is_write) begin
        ad_out  <= wdata;
        cmd_out <= CMD_DATA;
      end else begin
        drive <= 1'b0;
      end
      if (fifo_push && rd_pending)
        rd_pending <= 1'b0;
    end
  end

  assign bus.proc_drive_valid_n = ~drive;
  assign bus.ad_proc_out        = ad_out;
  assign bus.cmd_proc_out       = cmd_out;
  assign bus.ad_proc_oe         = drive;
  assign bus.cmd_proc_oe        = drive;
  assign bus.parity_proc_out    = 1'b0;
  assign bus.parity_proc_oe     = drive;
  assign bus.release_n          = ~(state == SBH_SLAVE);

  // Mode loader
  logic [DIV_W-1:0]      div;
  logic                  mclk;
  logic [MODE_CNT_W-1:0] bit_cnt;
  logic                  loading;
  logic                  pg_d;
  logic [MODE_BITS-1:0]  mode;
  wire pg_rise  = pg_s[1] & ~pg_d;
  wire div_wrap = (div == DIV_W'(MCLK_DIV-1));
  wire mclk_rise = div == DIV_W'(MCLK_DIV/2 - 1);
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div     <= '0;
      mclk    <= 1'b0;
      bit_cnt <= '0;
      loading <= 1'b0;
      pg_d    <= 1'b0;
      mode    <= '0;
      mode_done_out <= 1'b0;
    end else begin
      pg_d <= pg_s[1];
      div  <= div_wrap ? '0 : div + 1'b1;
      if (mclk_rise)
        mclk <= 1'b1;
      else if (div_wrap)
        mclk <= 1'b0;
      if (pg_rise) begin
        loading       <= 1'b1;
        bit_cnt       <= '0;
        mode_done_out <= 1'b0;
      end else if (loading && mclk_rise) begin
        mode[bit_cnt] <= md_s[1];
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == MODE_CNT_W'(MODE_BITS-1)) begin
          loading       <= 1'b0;
          mode_done_out <= 1'b1;
        end
      end
    end
  end
  assign bus.mode_clk   = mclk;
  assign mode_bits_out  = mode;
  // One bit wider than the field, so the largest multiplier does not wrap
  assign pipe_mult_out  = 4'(mode[MODE_MULT_HI:MODE_MULT_LO])
                          + 4'(MULT_BASE);
endmodule

// File: hdl/sbh_pkg.sv
package sbh_pkg;
  localparam int AD_W        = 32;
  localparam int CMD_W       = 9;
  localparam int MODE_BITS   = 256;
  localparam int MODE_CNT_W  = 8;
  localparam int MCLK_DIV    = 256;
  localparam int DIV_W       = 8;
  localparam int FIFO_DEPTH  = 4;
  // Command bus encodings used by both ends
  localparam logic [CMD_W-1:0] CMD_READ  = 9'h000;
  localparam logic [CMD_W-1:0] CMD_WRITE = 9'h040;
  localparam logic [CMD_W-1:0] CMD_DATA  = 9'h100;
  localparam logic [CMD_W-1:0] CMD_NULL  = 9'h180;
  localparam int CMD_RD_BIT   = 6;
  localparam int CMD_DATA_BIT = 8;
  // Mode stream fields
  localparam int MODE_MULT_LO = 5;
  localparam int MODE_MULT_HI = 7;
  localparam logic [2:0] MULT_BASE = 3'h2;
endpackage

// File: hdl/sbh_if.sv
`timescale 1ns/1ps
interface sbh_if;
  import sbh_pkg::*;
  logic                 ext_bus_request_n;
  logic                 release_n;
  logic                 proc_drive_valid_n;
  logic                 agent_drive_valid_n;
  logic                 read_accept_n;
  logic                 write_accept_n;
  logic [AD_W-1:0]      ad_proc_out;
  logic                 ad_proc_oe;
  logic [AD_W-1:0]      ad_agent_out;
  logic                 ad_agent_oe;
  logic [CMD_W-1:0]     cmd_proc_out;
  logic                 cmd_proc_oe;
  logic [CMD_W-1:0]     cmd_agent_out;
  logic                 cmd_agent_oe;
  logic                 parity_proc_out;
  logic                 parity_proc_oe;
  logic                 mode_clk;
  logic                 mode_data;
  logic                 power_good;
  // Resolved bus levels
  wire [AD_W-1:0]  shared_addr_data_bus = ad_proc_oe ? ad_proc_out :
                   ad_agent_oe ? ad_agent_out : '0;
  wire [CMD_W-1:0] command_id_bus = cmd_proc_oe ? cmd_proc_out :
                   cmd_agent_oe ? cmd_agent_out : '0;
  wire             command_parity = parity_proc_oe & parity_proc_out;
  modport proc (
    input  ext_bus_request_n, agent_drive_valid_n, read_accept_n,
    input  write_accept_n, shared_addr_data_bus, command_id_bus,
    input  command_parity, mode_data, power_good,
    output release_n, proc_drive_valid_n, ad_proc_out, ad_proc_oe,
    output cmd_proc_out, cmd_proc_oe, parity_proc_out, parity_proc_oe,
    output mode_clk
  );
  modport agent (
    input  release_n, proc_drive_valid_n, shared_addr_data_bus,
    input  command_id_bus, mode_clk,
    output ext_bus_request_n, agent_drive_valid_n, read_accept_n,
    output write_accept_n, ad_agent_out, ad_agent_oe, cmd_agent_out,
    output cmd_agent_oe, mode_data, power_good
  );
endinterface

// File: hdl/sbh_fifo.sv
`timescale 1ns/1ps
module sbh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire push = in_valid_in & in_ready_out;
  wire pop  = out_valid_out & out_ready_in;
  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end
endmodule

// File: hdl/sbh_agent_end.sv
`timescale 1ns/1ps
module sbh_agent_end
  import sbh_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      sys_rst_in,
  // Link
  sbh_if.agent                           bus,
  // Acceptance and bus takeover controls
  input  wire logic                      read_ok_in,
  input  wire logic                      write_ok_in,
  input  wire logic                      take_bus_in,
  // Data to return or push
  input  wire logic                      push_valid_in,
  input  wire logic [sbh_pkg::AD_W-1:0]  push_data_in,
  output logic                           push_ready_out,
  // Processor requests seen
  output logic                           seen_valid_out,
  output logic                           seen_write_out,
  output logic [sbh_pkg::AD_W-1:0]       seen_addr_out,
  output logic [sbh_pkg::AD_W-1:0]       seen_wdata_out,
  // Mode source
  input  wire logic                      power_good_in,
  input  wire logic [sbh_pkg::MODE_BITS-1:0] mode_word_in
);
  import sbh_pkg::*;
  logic [1:0] mc_s;
  logic [MODE_CNT_W-1:0] mbit;
  logic mc_d;
  logic drive;
  logic [AD_W-1:0] drv_data;
  logic got_addr;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mc_s   <= 2'h0;
    end else begin
      mc_s   <= {mc_s[0], bus.mode_clk};
    end
  end
  // Same clock as the processor: valid and ownership are read undelayed so
  // they stay aligned with the bus word, and drive stops with the release
  wire pv    = ~bus.proc_drive_valid_n;
  wire owned = ~bus.release_n;
  wire [CMD_W-1:0] cmd = bus.command_id_bus;
  // Bus sampled late enough that processor drive is stable
  wire is_data = cmd[CMD_DATA_BIT];
  wire want  = take_bus_in | got_addr & ~seen_write_out;
  assign push_ready_out = owned & ~drive;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seen_valid_out <= 1'b0;
      seen_write_out <= 1'b0;
      seen_addr_out  <= '0;
      seen_wdata_out <= '0;
      got_addr       <= 1'b0;
      drive          <= 1'b0;
      drv_data       <= '0;
      mbit           <= '0;
      mc_d           <= 1'b0;
    end else begin
      seen_valid_out <= 1'b0;
      mc_d <= mc_s[1];
      if (pv && !is_data) begin
        got_addr       <= 1'b1;
        seen_write_out <= cmd[CMD_RD_BIT];
        seen_addr_out  <= bus.shared_addr_data_bus;
        seen_valid_out <= ~cmd[CMD_RD_BIT];
      end else if (pv && is_data) begin
        seen_wdata_out <= bus.shared_addr_data_bus;
        seen_valid_out <= 1'b1;
        got_addr       <= 1'b0;
      end
      drive <= 1'b0;
      if (push_valid_in && push_ready_out) begin
        drive    <= 1'b1;
        drv_data <= push_data_in;
        got_addr <= 1'b0;
      end
      if (!power_good_in)
        mbit <= '0;
      else if (mc_s[1] && !mc_d)
        mbit <= mbit + 1'b1;
    end
  end
  assign bus.ext_bus_request_n   = ~want;
  assign bus.read_accept_n       = ~read_ok_in;
  assign bus.write_accept_n      = ~write_ok_in;
  assign bus.agent_drive_valid_n = ~(drive & owned);
  assign bus.ad_agent_out        = drv_data;
  assign bus.ad_agent_oe         = drive & owned;
  assign bus.cmd_agent_out       = CMD_DATA;
  assign bus.cmd_agent_oe        = drive & owned;
  assign bus.power_good          = power_good_in;
  assign bus.mode_data           = mode_word_in[mbit];
endmodule

// File: verif/sbh_chk.sv
`timescale 1ns/1ps
module sbh_chk
  import sbh_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      sys_rst_in,
  // Handshakes
  input  wire logic                      ext_bus_request_n,
  input  wire logic                      release_n,
  input  wire logic                      proc_drive_valid_n,
  input  wire logic                      agent_drive_valid_n,
  // Processor drivers and resolved lines
  input  wire logic                      ad_proc_oe,
  input  wire logic                      cmd_proc_oe,
  input  wire logic [sbh_pkg::CMD_W-1:0] command_id_bus,
  input  wire logic                      command_parity,
  input  wire logic                      mode_clk
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_rd_addr;
    !proc_drive_valid_n && command_id_bus == CMD_READ;
  endsequence
  sequence s_wr_addr;
    !proc_drive_valid_n && command_id_bus == CMD_WRITE;
  endsequence
  sequence s_data_beat;
    !proc_drive_valid_n && command_id_bus[CMD_DATA_BIT];
  endsequence

  property p_valid_drives;
    !proc_drive_valid_n |-> ad_proc_oe && cmd_proc_oe;
  endproperty
  property p_parity_zero;
    command_parity == 1'b0;
  endproperty
  property p_release_off;
    !release_n |-> !ad_proc_oe && !cmd_proc_oe;
  endproperty
  property p_agent_owns;
    !agent_drive_valid_n |-> !release_n;
  endproperty
  property p_rd_release;
    s_rd_addr |-> ##2 !release_n;
  endproperty
  property p_wr_data;
    s_wr_addr |=> s_data_beat;
  endproperty
  // A read keeps the processor quiet well past its release
  property p_one_out;
    s_rd_addr |=> proc_drive_valid_n [*4];
  endproperty
  property p_ext_grant;
    $fell(ext_bus_request_n) |-> ##[0:200] !release_n;
  endproperty
  property p_mode_period;
    $rose(mode_clk) |-> ##256 $rose(mode_clk);
  endproperty

  a_valid_drives: assert property (p_valid_drives)
    else $error("output valid without drivers on");
  a_parity_zero: assert property (p_parity_zero)
    else $error("command parity not zero");
  a_release_off: assert property (p_release_off)
    else $error("processor drives while released");
  a_agent_owns: assert property (p_agent_owns)
    else $error("agent valid while processor owns bus");
  a_rd_release: assert property (p_rd_release)
    else $error("read not followed by release");
  a_wr_data: assert property (p_wr_data)
    else $error("write address not followed by data");
  a_one_out: assert property (p_one_out)
    else $error("second request while read outstanding");
  a_ext_grant: assert property (p_ext_grant)
    else $error("external request not granted");
  a_mode_period: assert property (p_mode_period)
    else $error("mode clock period wrong");
endmodule

// File: verif/sys_bus_handshake_boot_mode_tb.sv
`timescale 1ns/1ps
module sys_bus_handshake_boot_mode_tb;
  import sbh_pkg::*;
  localparam logic [MODE_BITS-1:0] MODE_PAT = {8{32'h5a3c96a5}};
  logic                 core_clk_in, sys_rst_in;
  logic                 req_valid_in, req_ready_out, req_write_in;
  logic [AD_W-1:0]      req_addr_in, req_wdata_in, rsp_data_out;
  logic [AD_W-1:0]      push_data_in, seen_addr_out, seen_wdata_out;
  logic                 rsp_valid_out, rsp_ready_in, mode_done_out;
  logic [MODE_BITS-1:0] mode_bits_out, mode_word_in;
  logic [3:0]           pipe_mult_out;
  logic                 read_ok_in, write_ok_in, take_bus_in;
  logic                 push_valid_in, push_ready_out, power_good_in;
  logic                 seen_valid_out, seen_write_out, last_clk;
  int                   n_mismatch = 0, checked = 0, n, m, rises;

  sbh_if i_sbh_if ();
  sbh_proc_end i_sbh_proc_end (
    .core_clk_in, .sys_rst_in, .bus (i_sbh_if), .req_valid_in,
    .req_ready_out, .req_write_in, .req_addr_in, .req_wdata_in,
    .rsp_valid_out, .rsp_ready_in, .rsp_data_out, .mode_done_out,
    .mode_bits_out, .pipe_mult_out
  );
  sbh_agent_end i_sbh_agent_end (
    .core_clk_in, .sys_rst_in, .bus (i_sbh_if), .read_ok_in,
    .write_ok_in, .take_bus_in, .push_valid_in, .push_data_in,
    .push_ready_out, .seen_valid_out, .seen_write_out, .seen_addr_out,
    .seen_wdata_out, .power_good_in, .mode_word_in
  );
  sbh_chk i_sbh_chk (
    .core_clk_in, .sys_rst_in,
    .ext_bus_request_n   (i_sbh_if.ext_bus_request_n),
    .release_n           (i_sbh_if.release_n),
    .proc_drive_valid_n  (i_sbh_if.proc_drive_valid_n),
    .agent_drive_valid_n (i_sbh_if.agent_drive_valid_n),
    .ad_proc_oe          (i_sbh_if.ad_proc_oe),
    .cmd_proc_oe         (i_sbh_if.cmd_proc_oe),
    .command_id_bus      (i_sbh_if.command_id_bus),
    .command_parity      (i_sbh_if.command_parity),
    .mode_clk            (i_sbh_if.mode_clk)
  );

  task automatic check(input string what,
                       input logic [MODE_BITS-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic proc_req(input logic wr, input logic [AD_W-1:0] a, d);
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_valid_in <= 1'b1;
    n = 0;
    do @(posedge core_clk_in);
    while (req_ready_out !== 1'b1 && n++ < 60);
    check("req_taken", req_ready_out, 1'b1);
    req_valid_in <= 1'b0;
  endtask

  task automatic push_word(input logic [AD_W-1:0] d);
    push_data_in <= d;
    push_valid_in <= 1'b1;
    n = 0;
    do @(posedge core_clk_in);
    while (push_ready_out !== 1'b1 && n++ < 40);
    check("push_ready", push_ready_out, 1'b1);
    push_valid_in <= 1'b0;
  endtask

  task automatic get_word(input logic [AD_W-1:0] d);
    for (n = 0; n < 40 && rsp_valid_out !== 1'b1; n++)
      @(posedge core_clk_in);
    check("rsp_valid", rsp_valid_out, 1'b1);
    check("rsp_data", rsp_data_out, d);
  endtask

  task automatic proc_write(input logic [AD_W-1:0] a, d);
    proc_req(1'b1, a, d);
    for (n = 0; n < 20 && seen_valid_out !== 1'b1; n++)
      @(posedge core_clk_in);
    check("seen_valid", seen_valid_out, 1'b1);
    check("seen_write", seen_write_out, 1'b1);
    check("seen_addr", seen_addr_out, a);
    check("seen_wdata", seen_wdata_out, d);
  endtask

  task automatic proc_read(input logic [AD_W-1:0] a, d);
    proc_req(1'b0, a, '0);
    for (n = 0; n < 20 && i_sbh_if.release_n !== 1'b0; n++)
      @(posedge core_clk_in);
    check("rd_release", i_sbh_if.release_n, 1'b0);
    check("rd_busy", req_ready_out, 1'b0);
    push_word(d);
    get_word(d);
  endtask

  task automatic wait_release(input logic lvl);
    for (n = 0; n < 40 && i_sbh_if.release_n !== lvl; n++)
      @(posedge core_clk_in);
  endtask

  // Fill the receive buffer with the user stalled: a full buffer must keep
  // the processor in slave state, then the words drain in order
  task automatic fifo_test;
    rsp_ready_in <= 1'b0;
    take_bus_in <= 1'b1;
    wait_release(1'b0);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      push_word(32'h10 + AD_W'(i));
      @(posedge core_clk_in);
    end
    take_bus_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    check("f_full", {rsp_valid_out, i_sbh_if.release_n}, 2'b10);
    rsp_ready_in <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      @(posedge core_clk_in);
      check("f_valid", rsp_valid_out, 1'b1);
      check("f_out", rsp_data_out, 32'h10 + AD_W'(i));
    end
    @(posedge core_clk_in);
    check("f_empty", rsp_valid_out, 1'b0);
    wait_release(1'b1);
    check("f_handback", i_sbh_if.release_n, 1'b1);
  endtask

  task automatic bus_tests;
    for (int i = 0; i < 3; i++)
      proc_write(32'h1000 + AD_W'(4 * i), 32'hc0de0000 ^ AD_W'(i));
    for (int w = 0; w < 2; w++) begin
      read_ok_in <= w[0];
      write_ok_in <= !w[0];
      repeat (4) @(posedge core_clk_in);
      fork
        begin
          repeat (6) @(posedge core_clk_in);
          check("req_held", req_ready_out, 1'b0);
          read_ok_in <= 1'b1;
          write_ok_in <= 1'b1;
        end
      join_none
      if (w == 1)
        proc_write(32'h2000, 32'h12345678);
      else
        proc_read(32'h3000, 32'h87654321);
    end
    proc_read(32'h3004, 32'h0badcafe);
    wait_release(1'b1);
    take_bus_in <= 1'b1;
    wait_release(1'b0);
    check("ext_release", i_sbh_if.release_n, 1'b0);
    push_word(32'h5555aaaa);
    get_word(32'h5555aaaa);
    take_bus_in <= 1'b0;
    wait_release(1'b1);
    check("handback", i_sbh_if.release_n, 1'b1);
    proc_write(32'h4000, 32'hfeedf00d);
    fifo_test();
  endtask

  task automatic mode_load;
    power_good_in <= 1'b1;
    for (m = 0; m < 70000 && mode_done_out !== 1'b1; m++)
      @(posedge core_clk_in);
    check("mode_done", mode_done_out, 1'b1);
    check("mode_bits", mode_bits_out, MODE_PAT);
    check("mult", pipe_mult_out, 4'(MODE_PAT[7:5]) + 4'(MULT_BASE));
    // Fresh serial data after loading must leave the captured modes alone
    mode_word_in <= ~MODE_PAT;
    rises = 0;
    last_clk = i_sbh_if.mode_clk;
    repeat (600) begin
      @(posedge core_clk_in);
      rises += int'(i_sbh_if.mode_clk & !last_clk);
      last_clk = i_sbh_if.mode_clk;
    end
    check("mode_clk_runs", rises >= 2, 1'b1);
    check("mode_hold", mode_bits_out, MODE_PAT);
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // Mode loading takes 256 slow clocks, so it runs beside the bus tests
  initial begin
    sys_rst_in = 1'b1;
    {req_valid_in, req_write_in, take_bus_in, push_valid_in} = '0;
    power_good_in = 1'b0;
    {req_addr_in, req_wdata_in, push_data_in} = '0;
    {read_ok_in, write_ok_in, rsp_ready_in} = '1;
    mode_word_in = MODE_PAT;
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    fork
      mode_load();
      bus_tests();
    join
    test_done();
  end

  initial begin
    repeat (80000) @(posedge core_clk_in);
    n_mismatch++;
    test_done();
  end
endmodule
